// *** verilog/fsq_pkg.sv ***
// Shared constants and types for the flash self-program sequencer
`default_nettype none
package fsq_pkg;
    // Register indices on the device's own register port
    localparam logic [3:0]  FSQ_REG_CONTROL   = 4'h0;
    localparam logic [3:0]  FSQ_REG_KEY       = 4'h1;
    // Control register fields
    localparam int          FSQ_CTL_START_BIT = 15;
    localparam int          FSQ_CTL_ERASE_BIT = 6;
    localparam logic [15:0] FSQ_CTL_RESET     = 16'h0000;
    localparam logic [3:0]  FSQ_OP_ROW        = 4'h1;
    localparam logic [3:0]  FSQ_OP_WORD       = 4'h3;
    localparam logic [3:0]  FSQ_OP_PAGE       = 4'h2;
    localparam logic [15:0] FSQ_CMD_PAGE_ERASE = 16'h4042;
    localparam logic [15:0] FSQ_CMD_ROW_PROG   = 16'h4001;
    localparam logic [15:0] FSQ_CMD_WORD_PROG  = 16'h4003;
    // Unlock key values
    localparam logic [7:0]  FSQ_KEY_FIRST     = 8'h55;
    localparam logic [7:0]  FSQ_KEY_SECOND    = 8'hAA;
    // Array geometry
    localparam int          FSQ_ROW_WORDS     = 64;
    localparam int          FSQ_ROW_BYTES     = 192;
    localparam int          FSQ_PAGE_ROWS     = 8;
    localparam int          FSQ_PAGE_BYTES    = 1536;
    localparam int          FSQ_PAGE_IGN_BITS = 10;
    localparam int          FSQ_ROW_IGN_BITS  = 7;
    localparam int          FSQ_ADDR_W        = 24;
    localparam int          FSQ_WORD_W        = 24;
    // Self-timed operation lengths at 20 MHz
    localparam int          FSQ_CLK_MHZ       = 20;
    localparam int          FSQ_T_PROG_US     = 20;
    localparam int          FSQ_T_ERASE_US    = 200;
    localparam int          FSQ_PROG_CYC  = FSQ_T_PROG_US * FSQ_CLK_MHZ;
    localparam int          FSQ_ERASE_CYC = FSQ_T_ERASE_US * FSQ_CLK_MHZ;
    localparam int          FSQ_TMR_W         = 13;
    typedef enum logic [2:0] {
        FSQ_IDLE = 3'b001,
        FSQ_BUSY = 3'b010,
        FSQ_DONE = 3'b100
    } fsq_state_t;
endpackage : fsq_pkg
`default_nettype wire

// *** verilog/fsq_if.sv ***
// Link between processor core end and flash sequencer end
`default_nettype none
interface fsq_if (
    input wire logic clk,
    input wire logic reset_n
);
    import fsq_pkg::*;
    logic [FSQ_ADDR_W-1:0] tbl_addr;
    logic [15:0]           tbl_data;
    logic                  tbl_wr_lo;
    logic                  tbl_wr_hi;
    logic [3:0]            reg_addr;
    logic [15:0]           reg_wdata;
    logic                  reg_wr;
    logic                  reg_rd;
    logic [15:0]           reg_rdata;
    logic                  cpu_stall;
    logic                  hard_reset;
    modport dev  (input tbl_addr, tbl_data, tbl_wr_lo, tbl_wr_hi, reg_addr,
                  reg_wdata, reg_wr, reg_rd, hard_reset,
                  output reg_rdata, cpu_stall);
    modport core (output tbl_addr, tbl_data, tbl_wr_lo, tbl_wr_hi, reg_addr,
                  reg_wdata, reg_wr, reg_rd,
                  input reg_rdata, cpu_stall);
endinterface : fsq_if
`default_nettype wire

// *** verilog/fsq_device.sv ***
// Flash self-program sequencer: holding buffers, unlock, timed operation
// Function
// - Key register write-only, reads zero, upper byte ignored
// - Rows hold 64 words, 192 bytes
// - Erase eight rows, program one row, aligned
// - Last table write address selects programmed row
// - Single-buffer variant programs one word only
// - Table writes only fill holding buffers
// - Start bit 15 launches timed operation
// - Hardware clears start bit at completion
// - Core stalled during whole operation
// - Interrupts held pending until operation ends
// - Power-on or brown-out reset aborts operation
// - Other resets held pending until completion
// - Page erase ignores ten low address bits
// - Keys 0x55 then 0xAA unlock start
// - Software places two no-ops after start
// - Page erase selected by 0x4042
// - Program each word at most twice
// - Row program selected by 0x4001
// - Word program selected by 0x4003
//
// The placing of the registers and strobed register access were left to the implementer.
`default_nettype none
module fsq_device #(
    parameter bit MULTI_BUF = 1'b1
) (
    // Core side
    fsq_if.dev                          bus,
    input  wire logic                   clk,
    input  wire logic                   reset_n,
    // Pending events from the rest of the chip
    input  wire logic                   irq_in,
    input  wire logic                   soft_reset_req,
    output logic                        irq_out,
    output logic                        soft_reset_out,
    // Flash array port
    output logic                        arr_prog,
    output logic                        arr_erase,
    output logic [fsq_pkg::FSQ_ADDR_W-1:0] arr_addr,
    output logic [fsq_pkg::FSQ_WORD_W*fsq_pkg::FSQ_ROW_WORDS-1:0] arr_data,
    output logic                        busy
);
    import fsq_pkg::*;

    localparam int NBUF = MULTI_BUF ? FSQ_ROW_WORDS : 1;

    fsq_state_t              st_q, st_d;
    logic [15:0]             ctl_q, ctl_d;
    logic                    key1_q, key1_d;
    logic                    armed_q, armed_d;
    logic [FSQ_TMR_W-1:0]    tmr_q, tmr_d;
    logic [FSQ_ADDR_W-1:0]   addr_q, addr_d;
    logic [15:0]             rdata_q, rdata_d;
    logic                    irq_pend_q, irq_pend_d;
    logic                    rst_pend_q, rst_pend_d;
    logic [FSQ_WORD_W-1:0]   buf_q [NBUF];
    logic [5:0]              slot;
    logic                    key_wr, ctl_wr, start_req, op_erase;

    assign key_wr  = bus.reg_wr && bus.reg_addr == FSQ_REG_KEY;
    assign ctl_wr  = bus.reg_wr && bus.reg_addr == FSQ_REG_CONTROL;
    assign op_erase = ctl_q[FSQ_CTL_ERASE_BIT];
    // Start only from idle, with the unlock armed
    assign start_req = ctl_wr && bus.reg_wdata[FSQ_CTL_START_BIT]
                       && armed_q && st_q == FSQ_IDLE;
    // Words sit two addresses apart, so bits 6:1 pick the buffer
    assign slot = MULTI_BUF ? bus.tbl_addr[FSQ_ROW_IGN_BITS-1:1] : 6'h00;

    always_comb begin
        st_d       = st_q;
        ctl_d      = ctl_q;
        key1_d     = key1_q;
        armed_d    = armed_q;
        tmr_d      = tmr_q;
        addr_d     = addr_q;
        rdata_d    = 16'h0000;
        irq_pend_d = irq_pend_q | irq_in;
        rst_pend_d = rst_pend_q | soft_reset_req;
        // Unlock: second key must directly follow the first
        if (bus.reg_wr) begin
            armed_d = 1'b0;
            key1_d  = key_wr
                      && bus.reg_wdata[7:0] == FSQ_KEY_FIRST;
            if (key_wr && key1_q && bus.reg_wdata[7:0] == FSQ_KEY_SECOND)
                armed_d = 1'b1;
        end
        if (bus.tbl_wr_lo || bus.tbl_wr_hi)
            addr_d = bus.tbl_addr;
        if (ctl_wr && st_q == FSQ_IDLE) begin
            // Start bit never set by software directly
            ctl_d = {1'b0, bus.reg_wdata[14:0]};
        end
        unique case (st_q)
            FSQ_IDLE: begin
                if (start_req) begin
                    ctl_d[FSQ_CTL_START_BIT] = 1'b1;
                    st_d  = FSQ_BUSY;
                    tmr_d = bus.reg_wdata[FSQ_CTL_ERASE_BIT]
                          ? FSQ_TMR_W'(FSQ_ERASE_CYC - 1)
                          : FSQ_TMR_W'(FSQ_PROG_CYC - 1);
                end
            end
            FSQ_BUSY: begin
                if (tmr_q == '0)
                    st_d = FSQ_DONE;
                else
                    tmr_d = tmr_q - 1'b1;
            end
            FSQ_DONE: begin
                ctl_d[FSQ_CTL_START_BIT] = 1'b0;
                st_d = FSQ_IDLE;
            end
        endcase
        // Released once idle; a new event in that cycle must not be lost
        if (st_q == FSQ_IDLE) begin
            irq_pend_d = irq_in;
            rst_pend_d = soft_reset_req;
        end
        if (bus.reg_rd) begin
            if (bus.reg_addr == FSQ_REG_CONTROL)
                rdata_d = ctl_q;
            else
                rdata_d = 16'h0000;
        end
    end

    // Power-on and brown-out arrive as reset_n or hard_reset and abort
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q       <= FSQ_IDLE;
            ctl_q      <= FSQ_CTL_RESET;
            key1_q     <= 1'b0;
            armed_q    <= 1'b0;
            tmr_q      <= '0;
            addr_q     <= '0;
            rdata_q    <= 16'h0000;
            irq_pend_q <= 1'b0;
            rst_pend_q <= 1'b0;
        end else if (bus.hard_reset) begin
            st_q       <= FSQ_IDLE;
            ctl_q      <= FSQ_CTL_RESET;
            key1_q     <= 1'b0;
            armed_q    <= 1'b0;
            tmr_q      <= '0;
            rdata_q    <= 16'h0000;
            irq_pend_q <= 1'b0;
            rst_pend_q <= 1'b0;
        end else begin
            st_q       <= st_d;
            ctl_q      <= ctl_d;
            key1_q     <= key1_d;
            armed_q    <= start_req ? 1'b0 : armed_d;
            tmr_q      <= tmr_d;
            addr_q     <= addr_d;
            rdata_q    <= rdata_d;
            irq_pend_q <= irq_pend_d;
            rst_pend_q <= rst_pend_d;
        end
    end

    // Holding buffers: low write sets bits 15:0, high write bits 23:16
    generate
        for (genvar i = 0; i < NBUF; i++) begin : g_buf
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    buf_q[i] <= '0;
                end else if (slot == 6'(i) && st_q == FSQ_IDLE) begin
                    if (bus.tbl_wr_lo)
                        buf_q[i][15:0] <= bus.tbl_data;
                    if (bus.tbl_wr_hi)
                        buf_q[i][23:16] <= bus.tbl_data[7:0];
                end
            end
        end
        for (genvar j = 0; j < FSQ_ROW_WORDS; j++) begin : g_out
            assign arr_data[j*FSQ_WORD_W +: FSQ_WORD_W] =
                (j < NBUF) ? buf_q[j % NBUF] : '0;
        end
    endgenerate

    // Array only changes while the timed operation runs
    always_comb begin
        arr_addr = addr_q;
        if (op_erase)
            arr_addr[FSQ_PAGE_IGN_BITS-1:0] = '0;
        else if (ctl_q[3:0] == FSQ_OP_ROW && MULTI_BUF)
            arr_addr[FSQ_ROW_IGN_BITS-1:0] = '0;
    end
    assign arr_erase = st_q == FSQ_BUSY && op_erase
                       && ctl_q[3:0] == FSQ_OP_PAGE;
    assign arr_prog  = st_q == FSQ_BUSY && !op_erase
                       && (ctl_q[3:0] == FSQ_OP_WORD
                           || (ctl_q[3:0] == FSQ_OP_ROW && MULTI_BUF));
    assign busy           = st_q != FSQ_IDLE;
    assign bus.cpu_stall  = busy;
    assign irq_out        = irq_pend_q & ~busy;
    assign soft_reset_out = rst_pend_q & ~busy;
    assign bus.reg_rdata  = rdata_q;
endmodule : fsq_device
`default_nettype wire

// *** verilog/fsq_core.sv ***
// Processor-core end: turns software orders into table and register writes
`default_nettype none
module fsq_core (
    // Link
    fsq_if.core                         bus,
    input  wire logic                   clk,
    input  wire logic                   reset_n,
    // Software command port
    input  wire logic [3:0]             sw_addr,
    input  wire logic [15:0]            sw_wdata,
    input  wire logic                   sw_wr,
    input  wire logic                   sw_rd,
    output logic [15:0]                 sw_rdata,
    // Table write request
    input  wire logic [fsq_pkg::FSQ_ADDR_W-1:0] sw_tbl_addr,
    input  wire logic                   sw_tbl_lo,
    input  wire logic                   sw_tbl_hi,
    // Core stalled
    output logic                        stalled
);
    import fsq_pkg::*;

    logic [FSQ_ADDR_W-1:0] taddr_q, taddr_d;
    logic [15:0]           tdata_q, tdata_d;
    logic                  tlo_q, tlo_d, thi_q, thi_d;
    logic [3:0]            raddr_q, raddr_d;
    logic [15:0]           wdata_q, wdata_d;
    logic                  wr_q, wr_d, rd_q, rd_d;

    // Orders are held off while stalled; software must respect stalled
    always_comb begin
        taddr_d = taddr_q;
        tdata_d = tdata_q;
        raddr_d = raddr_q;
        wdata_d = wdata_q;
        tlo_d   = 1'b0;
        thi_d   = 1'b0;
        wr_d    = 1'b0;
        rd_d    = 1'b0;
        if (!bus.cpu_stall) begin
            if (sw_tbl_lo || sw_tbl_hi) begin
                taddr_d = sw_tbl_addr;
                tdata_d = sw_wdata;
                tlo_d   = sw_tbl_lo;
                thi_d   = sw_tbl_hi;
            end else begin
                raddr_d = sw_addr;
                wdata_d = sw_wdata;
                wr_d    = sw_wr;
                rd_d    = sw_rd;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            taddr_q <= '0;
            tdata_q <= 16'h0000;
            tlo_q   <= 1'b0;
            thi_q   <= 1'b0;
            raddr_q <= 4'h0;
            wdata_q <= 16'h0000;
            wr_q    <= 1'b0;
            rd_q    <= 1'b0;
        end else begin
            taddr_q <= taddr_d;
            tdata_q <= tdata_d;
            tlo_q   <= tlo_d;
            thi_q   <= thi_d;
            raddr_q <= raddr_d;
            wdata_q <= wdata_d;
            wr_q    <= wr_d;
            rd_q    <= rd_d;
        end
    end

    assign bus.tbl_addr  = taddr_q;
    assign bus.tbl_data  = tdata_q;
    assign bus.tbl_wr_lo = tlo_q;
    assign bus.tbl_wr_hi = thi_q;
    assign bus.reg_addr  = raddr_q;
    assign bus.reg_wdata = wdata_q;
    assign bus.reg_wr    = wr_q;
    assign bus.reg_rd    = rd_q;
    assign sw_rdata      = bus.reg_rdata;
    assign stalled       = bus.cpu_stall;
endmodule : fsq_core
`default_nettype wire

// *** dv/fsq_checker.sv ***
// Protocol checker for the link between core end and device end
`default_nettype none
module fsq_checker
    import fsq_pkg::*;
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        reset_n,
    // Link signals
    input wire logic        tbl_wr_lo,
    input wire logic        tbl_wr_hi,
    input wire logic [3:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic        cpu_stall,
    input wire logic        hard_reset
);
    timeunit 1ns;
    timeprecision 1ns;
    logic        key1_q;
    logic        arm_q;
    logic [12:0] cnt_q;

    // Shadow of the unlock state, rebuilt from the register writes
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            key1_q <= 1'b0;
            arm_q  <= 1'b0;
            cnt_q  <= 13'h0;
        end else begin
            cnt_q <= cpu_stall ? cnt_q + 13'h1 : 13'h0;
            if (hard_reset) begin
                key1_q <= 1'b0;
                arm_q  <= 1'b0;
            end else if (reg_wr) begin
                key1_q <= reg_addr == FSQ_REG_KEY
                          && reg_wdata[7:0] == FSQ_KEY_FIRST;
                arm_q  <= key1_q && reg_addr == FSQ_REG_KEY
                          && reg_wdata[7:0] == FSQ_KEY_SECOND;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    AST_KEY_READS_ZERO: assert property (
        reg_rd && reg_addr == FSQ_REG_KEY |=> reg_rdata == 16'h0000)
        else $error("key register read returned nonzero data");
    AST_ARMED_START: assert property (
        reg_wr && reg_addr == FSQ_REG_CONTROL && reg_wdata[15] && arm_q
        && !cpu_stall && !hard_reset |=> cpu_stall)
        else $error("armed start did not stall the core");
    AST_UNARMED_START: assert property (
        reg_wr && reg_addr == FSQ_REG_CONTROL && reg_wdata[15] && !arm_q
        && !cpu_stall |=> !cpu_stall)
        else $error("start without unlock stalled the core");
    AST_STALL_LENGTH: assert property (
        $fell(cpu_stall) && !$past(hard_reset) |->
        cnt_q == FSQ_PROG_CYC + 1 || cnt_q == FSQ_ERASE_CYC + 1)
        else $error("operation length off");
    AST_STALL_HOLDS: assert property (
        cpu_stall && !hard_reset && cnt_q < FSQ_PROG_CYC |=> cpu_stall)
        else $error("stall dropped early");
    AST_ABORT: assert property (
        hard_reset && cpu_stall |=> !cpu_stall)
        else $error("hard reset did not abort the operation");
    AST_CORE_QUIET: assert property (
        cpu_stall && $past(cpu_stall) |->
        !(reg_wr || reg_rd || tbl_wr_lo || tbl_wr_hi))
        else $error("core issued an order while stalled");
    AST_START_CLEARED: assert property (
        reg_rd && reg_addr == FSQ_REG_CONTROL && !cpu_stall
        |=> !reg_rdata[FSQ_CTL_START_BIT])
        else $error("start bit still set while idle");
endmodule : fsq_checker
`default_nettype wire

// *** dv/testbench.sv ***
// Directed bench: core end and device end joined by the link
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import fsq_pkg::*;
    logic                  clk, reset_n, sw_wr, sw_rd, stalled, busy;
    logic [3:0]            sw_addr;
    logic [15:0]           sw_wdata, sw_rdata;
    logic [23:0]           sw_tbl_addr, arr_addr;
    logic                  sw_tbl_lo, sw_tbl_hi, irq_in, soft_reset_req;
    logic                  irq_out, soft_reset_out, arr_prog, arr_erase;
    logic [24*64-1:0]      arr_data;
    int                    failures, check_count;

    fsq_if fsq_if_inst (.clk(clk), .reset_n(reset_n));
    fsq_device fsq_device_inst (.bus(fsq_if_inst), .clk(clk),
        .reset_n(reset_n), .irq_in(irq_in), .soft_reset_req(soft_reset_req),
        .irq_out(irq_out), .soft_reset_out(soft_reset_out),
        .arr_prog(arr_prog), .arr_erase(arr_erase), .arr_addr(arr_addr),
        .arr_data(arr_data), .busy(busy));
    fsq_core fsq_core_inst (.bus(fsq_if_inst), .clk(clk), .reset_n(reset_n),
        .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
        .sw_rdata(sw_rdata), .sw_tbl_addr(sw_tbl_addr), .sw_tbl_lo(sw_tbl_lo),
        .sw_tbl_hi(sw_tbl_hi), .stalled(stalled));
    fsq_checker fsq_checker_inst (.clk(clk), .reset_n(reset_n),
        .tbl_wr_lo(fsq_if_inst.tbl_wr_lo), .tbl_wr_hi(fsq_if_inst.tbl_wr_hi),
        .reg_addr(fsq_if_inst.reg_addr), .reg_wdata(fsq_if_inst.reg_wdata),
        .reg_wr(fsq_if_inst.reg_wr), .reg_rd(fsq_if_inst.reg_rd),
        .reg_rdata(fsq_if_inst.reg_rdata), .cpu_stall(fsq_if_inst.cpu_stall),
        .hard_reset(fsq_if_inst.hard_reset));

    always #25 clk = ~clk;

    task automatic report_and_stop;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic sw_write(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        sw_addr  <= a;
        sw_wdata <= d;
        sw_wr    <= 1'b1;
        @(posedge clk);
        sw_wr <= 1'b0;
    endtask : sw_write

    // Core forwards one cycle late, so data shows two edges after the order
    task automatic read_check(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk);
        sw_addr <= a;
        sw_rd   <= 1'b1;
        @(posedge clk);
        sw_rd <= 1'b0;
        @(posedge clk);
        #1;
        check(sw_rdata, exp);
    endtask : read_check

    task automatic tbl_write(input logic [23:0] a, input logic [23:0] d);
        @(posedge clk);
        sw_tbl_addr <= a;
        sw_wdata    <= d[15:0];
        sw_tbl_lo   <= 1'b1;
        @(posedge clk);
        sw_tbl_lo <= 1'b0;
        sw_wdata  <= {8'h00, d[23:16]};
        sw_tbl_hi <= 1'b1;
        @(posedge clk);
        sw_tbl_hi <= 1'b0;
    endtask : tbl_write

    task automatic wait_stall(input logic lvl, input int lim, output int n);
        n = 0;
        while (stalled !== lvl) begin
            @(posedge clk);
            #1;
            n++;
            if (n > lim) begin
                failures++;
                $display("wrong value at %0t: got %h expected %h",
                         $time, stalled, lvl);
                report_and_stop();
            end
        end
    endtask : wait_stall

    task automatic run_op(input logic [15:0] ctl, input int cyc,
                          input logic er, input logic [23:0] addr);
        int n;
        sw_write(FSQ_REG_KEY, 16'h0055);
        sw_write(FSQ_REG_KEY, 16'h00AA);
        sw_write(FSQ_REG_CONTROL, ctl);
        wait_stall(1'b1, 4, n);
        check(busy, 1'b1);
        check({arr_erase, arr_prog}, {er, !er});
        check(arr_addr, addr);
        wait_stall(1'b0, 5000, n);
        check(n, cyc);
    endtask : run_op

    task automatic t_refused;
        sw_write(FSQ_REG_KEY, 16'hFF55);
        read_check(FSQ_REG_KEY, 16'h0000);
        sw_write(FSQ_REG_CONTROL, 16'h4001);
        sw_write(FSQ_REG_KEY, 16'h00AA);
        sw_write(FSQ_REG_CONTROL, 16'hC001);
        repeat (4) @(posedge clk);
        #1;
        check(stalled, 1'b0);
        read_check(FSQ_REG_CONTROL, 16'h4001);
        sw_write(FSQ_REG_KEY, 16'h00AA);
        sw_write(FSQ_REG_KEY, 16'h0055);
        sw_write(FSQ_REG_CONTROL, 16'hC001);
        repeat (4) @(posedge clk);
        #1;
        check(stalled, 1'b0);
    endtask : t_refused

    task automatic t_erase;
        tbl_write(24'h0012A6, 24'h123456);
        fork
            run_op(16'hC042, FSQ_ERASE_CYC + 1, 1'b1, 24'h001000);
            begin
                repeat (30) @(posedge clk);
                irq_in         <= 1'b1;
                soft_reset_req <= 1'b1;
                @(posedge clk);
                irq_in         <= 1'b0;
                soft_reset_req <= 1'b0;
                @(posedge clk);
                #1;
                check({irq_out, soft_reset_out}, 2'b00);
            end
        join
        check({irq_out, soft_reset_out}, 2'b11);
        read_check(FSQ_REG_CONTROL, FSQ_CMD_PAGE_ERASE);
        // While idle the events pass straight through, one cycle late
        @(posedge clk);
        irq_in         <= 1'b1;
        soft_reset_req <= 1'b1;
        @(posedge clk);
        irq_in         <= 1'b0;
        soft_reset_req <= 1'b0;
        #1;
        check({irq_out, soft_reset_out}, 2'b11);
    endtask : t_erase

    task automatic t_row_and_word;
        tbl_write(24'h000E0A, 24'hBAD0BA);
        for (int k = 0; k < 64; k++)
            tbl_write(24'h000D00 + 24'(k * 2), 24'h5A0000 | 24'(k));
        check(arr_prog, 1'b0);
        run_op(16'hC001, FSQ_PROG_CYC + 1, 1'b0, 24'h000D00);
        for (int k = 0; k < 64; k++)
            check(arr_data[k*24 +: 24], 24'h5A0000 | 24'(k));
        tbl_write(24'h000D46, 24'h81C3E7);
        run_op(16'hC003, FSQ_PROG_CYC + 1, 1'b0, 24'h000D46);
        check(arr_data[35*24 +: 24], 24'h81C3E7);
        sw_write(FSQ_REG_CONTROL, 16'hC003);
        repeat (4) @(posedge clk);
        #1;
        check(stalled, 1'b0);
    endtask : t_row_and_word

    task automatic t_abort;
        int n;
        sw_write(FSQ_REG_KEY, 16'h0055);
        sw_write(FSQ_REG_KEY, 16'h00AA);
        sw_write(FSQ_REG_CONTROL, 16'hC042);
        wait_stall(1'b1, 4, n);
        repeat (50) @(posedge clk);
        fsq_if_inst.hard_reset <= 1'b1;
        @(posedge clk);
        fsq_if_inst.hard_reset <= 1'b0;
        wait_stall(1'b0, 3, n);
        read_check(FSQ_REG_CONTROL, 16'h0000);
        run_op(16'hC001, FSQ_PROG_CYC + 1, 1'b0, 24'h000D00);
    endtask : t_abort

    initial begin
        {clk, reset_n, sw_wr, sw_rd, sw_tbl_lo, sw_tbl_hi} = '0;
        {irq_in, soft_reset_req, sw_addr, sw_wdata, sw_tbl_addr} = '0;
        fsq_if_inst.hard_reset = 1'b0;
        failures    = 0;
        check_count = 0;
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        read_check(FSQ_REG_CONTROL, FSQ_CTL_RESET);
        t_refused();
        t_erase();
        t_row_and_word();
        t_abort();
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
